// File: design/sleep_ctrl_defs.vh
// constants for the cyclic sleep controller
`ifndef SLEEP_CTRL_DEFS_VH
`define SLEEP_CTRL_DEFS_VH

// apb register byte offsets
`define REG_CTRL 8'h00
`define REG_INACT 8'h04
`define REG_INITDUR 8'h08
`define REG_STATUS 8'h0C

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 3
`define CTRL_PINWAKE_BIT 4

// reset values and the inactivity minimum
`define MODE_RESET 4'h0
`define PINWAKE_RESET 1'b0
`define INACT_RESET 16'h0064
`define INACT_MIN 16'h0010
`define INITDUR_RESET 8'h01

// sleep mode codes
`define MODE_OFF 4'h0
`define MODE_PIN 4'h1
`define MODE_CYC_FIRST 4'h3
`define MODE_CYC_LAST 4'h8

// wake period of the shortest cyclic mode, in 100 ms ticks
`define CYC_BASE_TICKS 8'h05

// timing: clock rate, tick, detect and listen window
`define CLK_MHZ 250
`define TICK_MS 100
`define DETECT_MS 35
`define LISTEN_MS 50
`define TICK_CYC (`TICK_MS * `CLK_MHZ * 1000)
`define DETECT_CYC (`DETECT_MS * `CLK_MHZ * 1000)
`define LISTEN_CYC (`LISTEN_MS * `CLK_MHZ * 1000)

`endif

// File: design/tick_divider.v
// divider that makes the one-cycle 100 ms tick enable
`timescale 1ns/1ns
module tick_divider #(
  parameter [31:0] TICK_CYCLES = 32'd25000000
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // tick enable
  output reg tick
);

  reg [31:0] count;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (count >= TICK_CYCLES - 32'd1) begin
      count <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      count <= count + 32'd1;
      tick <= 1'b0;
    end
  end

endmodule

// File: design/cyclic_sleep_controller.v
// sleep and wake controller with apb registers
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "sleep_ctrl_defs.vh"
module cyclic_sleep_controller #(
  parameter [31:0] TICK_CYCLES = `TICK_CYC,
  parameter [31:0] DETECT_CYCLES = `DETECT_CYC,
  parameter [31:0] LISTEN_CYCLES = `LISTEN_CYC
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // pins
  input wire sleepPin,
  input wire initDetectPin,
  // radio activity, same clock
  input wire txActive,
  input wire rxActive,
  input wire txPending,
  input wire txStart,
  // status to the radio
  output reg radioOn,
  output reg listening,
  output reg rxSync,
  output reg initSending
);

  localparam [2:0] ST_ACTIVE = 3'd0;
  localparam [2:0] ST_SLEEP = 3'd1;
  localparam [2:0] ST_LISTEN = 3'd2;
  localparam [2:0] ST_SYNC = 3'd3;
  localparam [2:0] ST_PINSLEEP = 3'd4;

  function isCyclic;
    input [3:0] mode;
    begin
      isCyclic = (mode >= `MODE_CYC_FIRST) && (mode <= `MODE_CYC_LAST);
    end
  endfunction

  // wake period in ticks doubles with each code above the first cyclic one
  function [7:0] periodTicks;
    input [3:0] mode;
    reg [3:0] steps;
    begin
      steps = mode - `MODE_CYC_FIRST;
      periodTicks = `CYC_BASE_TICKS << steps[2:0];
    end
  endfunction

  // configuration
  reg [3:0] sleepModeSelect;
  reg pinWakeEnable;
  reg [15:0] inactivityTime;
  reg [7:0] initializerDuration;

  // pin synchronisers
  reg [2:0] pinSync;
  reg [2:0] detSync;
  reg pinLevel;
  reg detLevel;

  // state and counters
  reg [2:0] state;
  reg [2:0] next_state;
  reg [15:0] idleTicks;
  reg [7:0] sleepTicks;
  reg [31:0] windowCount;
  reg [31:0] detectCount;
  reg [7:0] initTicks;
  wire tick;

  tick_divider #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // a change counts only once the second and third stages agree
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pinSync <= 3'b000;
      detSync <= 3'b000;
      pinLevel <= 1'b0;
      detLevel <= 1'b0;
    end else begin
      pinSync <= {pinSync[1:0], sleepPin};
      detSync <= {detSync[1:0], initDetectPin};
      if (pinSync[1] == pinSync[2]) begin
        pinLevel <= pinSync[2];
      end
      if (detSync[1] == detSync[2]) begin
        detLevel <= detSync[2];
      end
    end
  end

  // decode terms
  // the sleep pin only matters in pin mode and, with pinWakeEnable set, in cyclic modes; every other mode ignores it
  wire cyclic = isCyclic(sleepModeSelect);
  wire pinWakeOn = cyclic && pinWakeEnable;
  wire pinHold = pinWakeOn && !pinLevel;
  wire activity = txActive || rxActive;
  wire idleDone = (idleTicks >= inactivityTime);
  wire windowDone = (windowCount >= LISTEN_CYCLES - 32'd1);
  wire detectDone = (detectCount >= DETECT_CYCLES - 32'd1);

  // state transitions
  always @* begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (sleepModeSelect == `MODE_PIN) begin
          if (pinLevel) begin
            next_state = ST_PINSLEEP;
          end
        end else if (cyclic && !pinHold && idleDone && !txPending && !activity) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!cyclic || pinHold || txPending) begin
          next_state = ST_ACTIVE;
        end else if (tick && sleepTicks >= periodTicks(sleepModeSelect) - 8'd1) begin
          next_state = ST_LISTEN;
        end
      end
      ST_LISTEN: begin
        // a detect still running when the window closes is lost; the far side must send longer
        if (!cyclic || pinHold || txPending) begin
          next_state = ST_ACTIVE;
        end else if (detLevel && detectDone) begin
          next_state = ST_SYNC;
        end else if (windowDone) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SYNC: begin
        // mode is not looked at here, so a sync in progress always runs to its end
        if (!detLevel) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_PINSLEEP: begin
        if (sleepModeSelect != `MODE_PIN || !pinLevel) begin
          next_state = ST_ACTIVE;
        end
      end
      default: begin
        next_state = ST_ACTIVE;
      end
    endcase
  end

  // modes 0, 2 and above 8 never leave the active state
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_ACTIVE;
      radioOn <= 1'b1;
      listening <= 1'b0;
      rxSync <= 1'b0;
    end else begin
      state <= next_state;
      radioOn <= (next_state != ST_SLEEP) && (next_state != ST_PINSLEEP);
      listening <= (next_state == ST_LISTEN) || (next_state == ST_SYNC);
      rxSync <= (state == ST_SYNC) && (next_state == ST_ACTIVE);
    end
  end

  // inactivity timer counts whole ticks while awake and idle
  // the tick runs free, so the idle time may end up to one tick short
  always @(posedge core_clk) begin
    if (sys_rst) begin
      idleTicks <= 16'h0000;
    end else if (state != ST_ACTIVE || activity || pinHold) begin
      idleTicks <= 16'h0000;
    end else if (tick && !idleDone) begin
      idleTicks <= idleTicks + 16'd1;
    end
  end

  // sleep period, listen window and detect counters
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sleepTicks <= 8'h00;
      windowCount <= 32'h0000_0000;
      detectCount <= 32'h0000_0000;
    end else begin
      if (state != ST_SLEEP) begin
        sleepTicks <= 8'h00;
      end else if (tick) begin
        sleepTicks <= sleepTicks + 8'd1;
      end
      if (state != ST_LISTEN) begin
        windowCount <= 32'h0000_0000;
      end else begin
        windowCount <= windowCount + 32'd1;
      end
      // the initializer must be seen without a break; any gap restarts the count
      if (state != ST_LISTEN || !detLevel) begin
        detectCount <= 32'h0000_0000;
      end else if (!detectDone) begin
        detectCount <= detectCount + 32'd1;
      end
    end
  end

  // initializer send timer; granularity is one tick, so the first tick may come early
  always @(posedge core_clk) begin
    if (sys_rst) begin
      initTicks <= 8'h00;
      initSending <= 1'b0;
    end else if (txStart && !initSending) begin
      initTicks <= initializerDuration;
      initSending <= (initializerDuration != 8'h00);
    end else if (initSending && tick) begin
      initTicks <= initTicks - 8'd1;
      if (initTicks == 8'd1) begin
        initSending <= 1'b0;
      end
    end
  end

  // apb: setup cycle prepares the answer, the access cycle completes at once
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire mapped = (paddr == `REG_CTRL) || (paddr == `REG_INACT) ||
                (paddr == `REG_INITDUR) || (paddr == `REG_STATUS);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        case (paddr)
          `REG_CTRL: begin
            prdata <= {27'h000_0000, pinWakeEnable, sleepModeSelect};
          end
          `REG_INACT: begin
            prdata <= {16'h0000, inactivityTime};
          end
          `REG_INITDUR: begin
            prdata <= {24'h00_0000, initializerDuration};
          end
          `REG_STATUS: begin
            // state code with the synced pin levels, for software to watch
            prdata <= {24'h00_0000, initSending, detLevel, pinLevel, 2'b00, state};
          end
          default: begin
            prdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // register writes; a too short inactivity time is raised to the minimum
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sleepModeSelect <= `MODE_RESET;
      pinWakeEnable <= `PINWAKE_RESET;
      inactivityTime <= `INACT_RESET;
      initializerDuration <= `INITDUR_RESET;
    end else if (access && pwrite) begin
      case (paddr)
        `REG_CTRL: begin
          sleepModeSelect <= pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
          pinWakeEnable <= pwdata[`CTRL_PINWAKE_BIT];
        end
        `REG_INACT: begin
          if (pwdata[15:0] < `INACT_MIN) begin
            inactivityTime <= `INACT_MIN;
          end else begin
            inactivityTime <= pwdata[15:0];
          end
        end
        `REG_INITDUR: begin
          initializerDuration <= pwdata[7:0];
        end
        // status and unmapped writes change nothing
        default: begin
          inactivityTime <= inactivityTime;
        end
      endcase
    end
  end

endmodule

// File: tb/remote_transmitter.sv
// far radio model sending wake initializers
`timescale 1ns/1ns
module remote_transmitter (
  // clock
  input wire core_clk,
  // initializer heard by the receiver
  output reg initDetectPin
);
  initial initDetectPin = 1'b0;
  // wait gap + 1 cycles, then send for len cycles; a short burst models a miss
  task burst(input int gap, input int len);
    begin
      repeat (gap + 1) @(posedge core_clk);
      initDetectPin <= 1'b1;
      repeat (len) @(posedge core_clk);
      initDetectPin <= 1'b0;
    end
  endtask
endmodule

// File: tb/sleep_ctrl_properties.sv
// checker for the sleep controller ports
`timescale 1ns/1ns
`include "sleep_ctrl_defs.vh"
module sleep_ctrl_properties (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  // radio
  input wire sleepPin,
  input wire initDetectPin,
  input wire txStart,
  input wire radioOn,
  input wire listening,
  input wire rxSync,
  input wire initSending
);
  reg [4:0] ctrl;
  reg [7:0] dur;
  wire [3:0] mode = ctrl[3:0];
  wire cyc = mode >= `MODE_CYC_FIRST && mode <= `MODE_CYC_LAST;
  wire awake = mode == `MODE_OFF || mode == 4'h2 || mode > `MODE_CYC_LAST;
  // settings follow the apb writes as they land
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl <= 5'h00;
      dur <= `INITDUR_RESET;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == `REG_CTRL)
        ctrl <= pwdata[4:0];
      if (paddr == `REG_INITDUR)
        dur <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  sequence quietListen;
    $rose(listening) ##1 (!initDetectPin)[*8];
  endsequence
  a_apb_zero_wait: assert property (psel && !penable |=> pready)
    else $error("apb not answered");
  a_off_stays_on: assert property (awake && $past(awake, 3) |-> radioOn)
    else $error("slept while disabled");
  a_rxsync_after_listen: assert property (rxSync |-> $past(listening) ##1 !rxSync)
    else $error("bad sync pulse");
  a_pin_hold_awake: assert property ((cyc && ctrl[4] && !sleepPin)[*8] |-> radioOn)
    else $error("pin hold ignored");
  a_pin_sleep_mode: assert property ((mode == `MODE_PIN && sleepPin)[*8] |-> !radioOn)
    else $error("pin sleep missed");
  a_listen_timeout: assert property (quietListen |-> ##[0:12] !listening)
    else $error("listen overran");
  a_init_start: assert property (txStart && dur != 8'h00 |=> initSending)
    else $error("initializer not sent");
  a_init_zero: assert property (txStart && dur == 8'h00 && !initSending |=> !initSending)
    else $error("zero initializer sent");
endmodule
bind cyclic_sleep_controller sleep_ctrl_properties i_props (.core_clk, .sys_rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .sleepPin, .initDetectPin, .txStart,
  .radioOn, .listening, .rxSync, .initSending);

// File: tb/tb.sv
// self-checking bench for the cyclic sleep controller
`timescale 1ns/1ns
`include "sleep_ctrl_defs.vh"
module tb;
  localparam int TK = 20;
  reg core_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0000_0000;
  reg sleepPin = 1'b1;
  reg rxActive = 1'b0;
  reg txActive = 1'b0;
  reg txPending = 1'b0;
  reg txStart = 1'b0;
  reg [31:0] rd;
  reg err;
  reg [15:0] lfsr = 16'h51F1;
  wire [31:0] prdata;
  wire pready, pslverr, initDetectPin, radioOn, listening, rxSync, initSending;
  int mismatches = 0;
  int cmpCount = 0;
  int cycles = 0;
  int n;
  int regm[3] = '{`MODE_RESET, `INACT_RESET, `INITDUR_RESET};
  int durs[$] = '{0, 1, 3};
  // listen window widened so a synchronised detect still fits inside it
  cyclic_sleep_controller #(.TICK_CYCLES(TK), .DETECT_CYCLES(7), .LISTEN_CYCLES(16)) i_dut (
    .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sleepPin, .initDetectPin, .txActive, .rxActive, .txPending,
    .txStart, .radioOn, .listening, .rxSync, .initSending);
  remote_transmitter i_far (.core_clk, .initDetectPin);
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      completeRun();
    end
  end
  function automatic [15:0] nextRand(input [15:0] s);
    nextRand = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input bit wr, input [7:0] a, input [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
    regm[a[3:2]] = a == `REG_INITDUR ? d[7:0] : a == `REG_CTRL ? d[4:0] : d[15:0];
    if (regm[1] < `INACT_MIN) regm[1] = `INACT_MIN;
  endtask
  task rdck(input [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, regm[a[3:2]]);
  endtask
  // which: 0 radio on, 1 listening, 2 sync pulse; n counts the cycles spent
  task waitOn(input int which, input bit v);
    n = 0;
    while ((which == 0 ? radioOn : which == 1 ? listening : rxSync) !== v && n < 9000) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task completeRun;
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      if (i > 2) begin
        lfsr = nextRand(lfsr);
        wr(8'(i % 3 * 4), {lfsr, lfsr});
      end
      rdck(8'(i % 3 * 4));
    end
    apb(1'b0, 8'h10, 32'h0000_0000);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    wr(`REG_CTRL, 32'h0000_0000);
    wr(`REG_INACT, 32'h0000_0005);
    rdck(`REG_INACT);
    repeat (400) @(posedge core_clk);
    check(radioOn, 1'b1);
    // status: active state, synced sleep pin high, no detect, nothing sending
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0020);
    // codes 2 and 9 are no sleep modes and must stay awake past the idle time
    for (int j = 2; j <= 9; j += 7) begin
      wr(`REG_CTRL, j);
      repeat (400) @(posedge core_clk);
      check(radioOn, 1'b1);
    end
    foreach (durs[k]) begin
      wr(`REG_INITDUR, durs[k]);
      txStart <= 1'b1;
      @(posedge core_clk);
      txStart <= 1'b0;
      n = 0;
      repeat (100) begin
        @(posedge core_clk);
        n += initSending;
      end
      check(durs[k] ? n >= (durs[k] - 1) * TK && n <= durs[k] * TK + 1 : n == 0, 1'b1);
    end
    // reception held while cyclic mode starts, so the idle count must restart
    rxActive <= 1'b1;
    wr(`REG_CTRL, 32'h0000_0003);
    repeat (150) @(posedge core_clk);
    rxActive <= 1'b0;
    waitOn(0, 1'b0);
    check(n >= 15 * TK && n <= 16 * TK + 4, 1'b1);
    for (int m = 3; m <= 8; m++) begin
      wr(`REG_CTRL, m);
      waitOn(1, 1'b1);
      waitOn(1, 1'b0);
      check(radioOn, 1'b0);
      waitOn(1, 1'b1);
      check(n >= (5 << (m - 3)) * TK - TK && n <= (5 << (m - 3)) * TK + 4, 1'b1);
    end
    wr(`REG_CTRL, 32'h0000_0003);
    waitOn(1, 1'b1);
    i_far.burst(0, 3);
    waitOn(1, 1'b0);
    check(radioOn, 1'b0);
    waitOn(1, 1'b1);
    i_far.burst(1, 40);
    check(listening, 1'b1);
    waitOn(2, 1'b1);
    check(n <= 8 && radioOn === 1'b1, 1'b1);
    // pending data holds the radio up past the idle time; a send restarts the count
    txPending <= 1'b1;
    repeat (400) @(posedge core_clk);
    check(radioOn, 1'b1);
    txPending <= 1'b0;
    txActive <= 1'b1;
    @(posedge core_clk);
    txActive <= 1'b0;
    waitOn(0, 1'b0);
    check(n >= 15 * TK && n <= 16 * TK + 4, 1'b1);
    wr(`REG_CTRL, 32'h0000_0013);
    waitOn(0, 1'b0);
    sleepPin <= 1'b0;
    repeat (8) @(posedge core_clk);
    check(radioOn, 1'b1);
    repeat (400) @(posedge core_clk);
    check(radioOn, 1'b1);
    sleepPin <= 1'b1;
    waitOn(0, 1'b0);
    check(n >= 15 * TK && n <= 16 * TK + 8, 1'b1);
    wr(`REG_CTRL, 32'h0000_0003);
    sleepPin <= 1'b0;
    repeat (10) @(posedge core_clk);
    check(radioOn, 1'b0);
    wr(`REG_CTRL, 32'h0000_0011);
    repeat (10) @(posedge core_clk);
    check(radioOn, 1'b1);
    sleepPin <= 1'b1;
    repeat (10) @(posedge core_clk);
    check(radioOn, 1'b0);
    completeRun();
  end
endmodule
